/* File: core/fpx_exc_unit.sv */
`timescale 1ns/1ps
`include "fpx_regs.svh"

module fpx_exc_unit
	import fpx_pkg::*;
#(
	parameter int NUM_OPS = 3,
	parameter int EXP_W   = `FPX_DP_EXP_W,
	parameter int FRAC_W  = `FPX_DP_FRAC_W
)
(
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           srst,
	// Issue stage, one instruction per valid cycle
	input  wire logic                           issueValid,
	input  wire logic                           issueArith,
	input  wire logic                           isDp,
	input  wire logic [NUM_OPS-1:0]             opValid,
	input  wire logic [NUM_OPS-1:0][EXP_W-1:0]  opExp,
	input  wire logic [NUM_OPS-1:0][FRAC_W-1:0] opFrac,
	input  wire logic signed [EXP_W+1:0]        initExp,
	input  wire logic signed [EXP_W+1:0]        ufThreshold,
	// Completion stage, one result per valid cycle
	input  wire logic                           resultValid,
	input  wire logic signed [EXP_W+1:0]        resExp,
	input  wire logic                           resFracAllOnes,
	input  wire logic                           resRoundInc,
	input  wire logic                           roundInexact,
	input  wire logic                           ovfUntrapped,
	input  wire logic                           ufLossUntrapped,
	// Control and software access
	input  wire logic [31:0]                    fpStatusCtrl,
	input  wire logic                           fastIeeeBypassMode,
	input  wire logic                           swWriteStatus,
	input  wire logic [31:0]                    swStatusValue,
	input  wire logic                           swWriteExc,
	input  wire logic [31:0]                    swExcValue,
	// Decision outputs
	output logic                                bounce,
	output fpx_cause_t                          bounceCause,
	output logic                                captureInstr,
	output logic                                preTriggerValid,
	output logic                                regWriteEn,
	output logic                                flushZeroResult,
	output logic                                ufTrapArmed,
	// Exception word flags
	output logic                                excPending,
	output logic                                excUnderflow,
	output logic                                excInvalid,
	// Sticky status flags
	output logic                                underflowSticky,
	output logic                                inexactSticky,
	output logic                                invalidSticky
);

	fpx_state_t         stReg;
	fpx_state_t         stNext;
	logic [NUM_OPS-1:0] opNan;
	logic [NUM_OPS-1:0] opSnan;
	logic [NUM_OPS-1:0] opSub;
	logic               flushZeroCtl;
	logic               defaultNan;
	logic               ufTrapEn;
	logic               ixTrapEn;
	logic               ioTrapEn;
	logic               anyNan;
	logic               anySnan;
	logic               anySub;
	logic               inputBounce;
	logic               snanDn;
	logic               potUf;
	logic               ftzFlush;
	logic               inexactEvent;
	logic               toMinNormal;

	// One classifier per operand slot
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OPS; gi++)
		begin : g_op
			fpx_operand_class
			#(
				.EXP_W     (EXP_W),
				.FRAC_W    (FRAC_W),
				.SP_EXP_W  (`FPX_SP_EXP_W),
				.SP_FRAC_W (`FPX_SP_FRAC_W)
			)
			u_class
			(
				.isDp        (isDp),
				.expField    (opExp[gi]),
				.fracField   (opFrac[gi]),
				.isNan       (opNan[gi]),
				.isSnan      (opSnan[gi]),
				.isSubnormal (opSub[gi])
			);
		end
	endgenerate

	// Control bits picked out of the status/control word
	assign flushZeroCtl = fpStatusCtrl[`FPX_SC_FLUSH_BIT];
	assign defaultNan   = fpStatusCtrl[`FPX_SC_DEF_NAN_BIT];
	assign ufTrapEn     = fpStatusCtrl[`FPX_SC_UF_TRAP_BIT];
	assign ixTrapEn     = fpStatusCtrl[`FPX_SC_IX_TRAP_BIT];
	assign ioTrapEn     = fpStatusCtrl[`FPX_SC_IO_TRAP_BIT];

	// Operand screening, only slots the instruction really reads
	assign anyNan  = |(opNan & opValid);
	assign anySnan = |(opSnan & opValid);
	assign anySub  = |(opSub & opValid);
	// A signalling NaN outside default NaN mode lands here too
	assign inputBounce = (anyNan & ~defaultNan)
		| (anySub & ~flushZeroCtl);
	assign snanDn      = anySnan & defaultNan;

	// Exponent is only a first estimate, so cancellation may still
	// pull the result under; bounce on the whole threshold band
	assign potUf = ~fastIeeeBypassMode
		& ~flushZeroCtl
		& (initExp < ufThreshold);

	// Flush test is on the unrounded exponent, so a value that would
	// round up to the minimum normal is still flushed
	assign ftzFlush    = flushZeroCtl
		& (resExp < `FPX_MIN_NORMAL_EXP);
	assign toMinNormal = (resExp == (`FPX_MIN_NORMAL_EXP - 13'sh0001))
		& resFracAllOnes & resRoundInc;
	assign inexactEvent = roundInexact | ovfUntrapped | ufLossUntrapped;

	// Next state; hardware events are applied after software writes
	// so a set in the same cycle as a clear is never lost
	always_comb
	begin
		stNext           = stReg;
		stNext.bounce    = 1'b0;
		stNext.capture   = 1'b0;
		stNext.preTrig   = 1'b0;
		stNext.regWrite  = 1'b0;
		stNext.flushZero = 1'b0;
		stNext.ufTrapArmed = ufTrapEn & ~flushZeroCtl;

		// Software is the only path that can clear a flag
		if (swWriteStatus)
		begin
			stNext.ufSticky = swStatusValue[`FPX_SC_UF_STICKY_BIT];
			stNext.ixSticky = swStatusValue[`FPX_SC_IX_STICKY_BIT];
			stNext.ioSticky = swStatusValue[`FPX_SC_IO_STICKY_BIT];
		end
		if (swWriteExc)
		begin
			stNext.excPending   = swExcValue[`FPX_XW_PEND_BIT];
			stNext.excUnderflow = swExcValue[`FPX_XW_UF_BIT];
			stNext.excInvalid   = swExcValue[`FPX_XW_IO_BIT];
		end

		// Issue decision in priority order
		if (issueValid)
		begin
			if (ixTrapEn)
			begin
				// Precise trap: core keeps the address, nothing captured
				stNext.bounce  = 1'b1;
				stNext.cause   = CAUSE_INEXACT;
				stNext.capture = 1'b0;
			end
			else if (issueArith && inputBounce)
			begin
				stNext.bounce     = 1'b1;
				stNext.cause      = CAUSE_INPUT;
				stNext.capture    = 1'b1;
				stNext.excPending = 1'b1;
			end
			else if (issueArith && snanDn && ioTrapEn)
			begin
				stNext.bounce     = 1'b1;
				stNext.cause      = CAUSE_INVALID;
				stNext.capture    = 1'b1;
				stNext.excPending = 1'b1;
				stNext.excInvalid = 1'b1;
			end
			else if (issueArith && snanDn)
			begin
				// Untrapped invalid: default NaN goes out, flag set;
				// a NaN result cannot underflow, so no bounce either
				stNext.ioSticky = 1'b1;
			end
			else if (issueArith && potUf)
			begin
				// Sticky left alone; support code owns it here
				stNext.bounce       = 1'b1;
				stNext.cause        = CAUSE_UNDERFLOW;
				stNext.capture      = 1'b1;
				stNext.excPending   = 1'b1;
				stNext.excUnderflow = 1'b1;
			end
		end

		// Completion; a bounced instruction never gets here, so its
		// registers keep their old contents
		if (resultValid && !ixTrapEn)
		begin
			stNext.regWrite = 1'b1;
			if (ftzFlush)
			begin
				stNext.flushZero = 1'b1;
				stNext.ufSticky  = 1'b1;
			end
			if (inexactEvent)
				stNext.ixSticky = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			stReg       <= '0;
			stReg.cause <= CAUSE_NONE;
		end
		else
			stReg <= stNext;
	end

	// Outputs straight from the state flip-flops
	assign bounce          = stReg.bounce;
	assign bounceCause     = stReg.cause;
	assign captureInstr    = stReg.capture;
	assign preTriggerValid = stReg.preTrig;
	assign regWriteEn      = stReg.regWrite;
	assign flushZeroResult = stReg.flushZero;
	assign ufTrapArmed     = stReg.ufTrapArmed;
	assign excPending      = stReg.excPending;
	assign excUnderflow    = stReg.excUnderflow;
	assign excInvalid      = stReg.excInvalid;
	assign underflowSticky = stReg.ufSticky;
	assign inexactSticky   = stReg.ixSticky;
	assign invalidSticky   = stReg.ioSticky;

	// Inexact trap wins and leaves nothing behind for the handler
	inexact_first_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && ixTrapEn && !swWriteExc
		|=> bounce && bounceCause == CAUSE_INEXACT && !captureInstr
			&& excPending == $past(excPending))
		else $error("inexact trap did not bounce first");

	inexact_precise_a: assert property (
		@(posedge clock) disable iff (srst)
		bounce && bounceCause == CAUSE_INEXACT |-> !captureInstr
			&& !preTriggerValid)
		else $error("inexact bounce captured an instruction");

	uf_bounce_flags_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && issueArith && !ixTrapEn && !inputBounce && !snanDn
			&& potUf && !swWriteExc
		|=> bounce && bounceCause == CAUSE_UNDERFLOW && excPending
			&& excUnderflow)
		else $error("potential underflow did not flag the exception word");

	ftz_no_uftrap_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && flushZeroCtl
		|=> !(bounce && bounceCause == CAUSE_UNDERFLOW) && !ufTrapArmed)
		else $error("underflow bounce taken in flush mode");

	uf_sticky_quiet_a: assert property (
		@(posedge clock) disable iff (srst)
		!swWriteStatus && !(resultValid && !ixTrapEn && ftzFlush)
		|=> underflowSticky == $past(underflowSticky))
		else $error("underflow sticky changed without cause");

	// The pulse may only stay up for a result completing right behind
	flush_zero_a: assert property (
		@(posedge clock) disable iff (srst)
		resultValid && !ixTrapEn && ftzFlush
		|=> flushZeroResult && underflowSticky && regWriteEn
			##1 (!flushZeroResult || $past(resultValid)))
		else $error("flush to zero not applied");

	// Both ends of the boundary: rounds-up value goes, minimum stays
	min_normal_a: assert property (
		@(posedge clock) disable iff (srst)
		resultValid && flushZeroCtl && !ixTrapEn
			&& (toMinNormal || resExp == `FPX_MIN_NORMAL_EXP)
		|=> flushZeroResult == $past(toMinNormal))
		else $error("flush decision wrong near minimum normal");

	inexact_sticky_a: assert property (
		@(posedge clock) disable iff (srst)
		resultValid && !ixTrapEn && inexactEvent
		|=> inexactSticky && regWriteEn)
		else $error("inexact event not recorded");

	input_bounce_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && issueArith && !ixTrapEn && inputBounce
		|=> bounce && bounceCause == CAUSE_INPUT && captureInstr)
		else $error("input exception did not bounce");

	snan_invalid_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && issueArith && !ixTrapEn && !inputBounce && snanDn
			&& !swWriteStatus && !swWriteExc
		|=> (ioTrapEn ? bounceCause == CAUSE_INVALID && excInvalid
			: invalidSticky && !bounce) == 1'b1)
		else $error("signalling NaN in default NaN mode mishandled");

	sticky_hold_a: assert property (
		@(posedge clock) disable iff (srst)
		inexactSticky && invalidSticky && !swWriteStatus
		|=> inexactSticky && invalidSticky)
		else $error("hardware cleared a sticky flag");

	// Disabled trap still bounces; support code writes the result
	uf_untrapped_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && issueArith && !ufTrapEn && !ixTrapEn && !inputBounce
			&& !snanDn && !flushZeroCtl && !fastIeeeBypassMode
			&& initExp < ufThreshold && !swWriteExc
		|=> bounce && bounceCause == CAUSE_UNDERFLOW && excUnderflow)
		else $error("untrapped potential underflow did not bounce");

	uf_trap_arm_a: assert property (
		@(posedge clock) disable iff (srst)
		ufTrapEn && !flushZeroCtl |=> ufTrapArmed)
		else $error("underflow trap enable not armed");

	fast_no_uf_a: assert property (
		@(posedge clock) disable iff (srst)
		issueValid && fastIeeeBypassMode
		|=> !(bounce && bounceCause == CAUSE_UNDERFLOW))
		else $error("underflow bounce taken in fast bypass mode");

endmodule

/* File: core/fpx_operand_class.sv */
`timescale 1ns/1ps

// Sorts one operand into NaN, signalling NaN and subnormal
module fpx_operand_class
#(
	parameter int EXP_W     = 11,
	parameter int FRAC_W    = 52,
	parameter int SP_EXP_W  = 8,
	parameter int SP_FRAC_W = 23
)
(
	// Operand fields, single precision in the low bits
	input  wire logic              isDp,
	input  wire logic [EXP_W-1:0]  expField,
	input  wire logic [FRAC_W-1:0] fracField,
	// Classification
	output logic                   isNan,
	output logic                   isSnan,
	output logic                   isSubnormal
);

	logic expMax;
	logic expZero;
	logic fracNonZero;
	logic quietBit;

	// Width depends on precision; SP fields sit right aligned
	always_comb
	begin
		expMax      = isDp ? (&expField) : (&expField[SP_EXP_W-1:0]);
		expZero     = isDp ? ~(|expField) : ~(|expField[SP_EXP_W-1:0]);
		fracNonZero = isDp ? (|fracField) : (|fracField[SP_FRAC_W-1:0]);
		quietBit    = isDp ? fracField[FRAC_W-1] : fracField[SP_FRAC_W-1];
		isNan       = expMax & fracNonZero;
		isSnan      = isNan & ~quietBit;
		isSubnormal = expZero & fracNonZero;
	end

endmodule

/* File: include/fpx_pkg.sv */
package fpx_pkg;

	// Reason the last instruction left the hardware path
	typedef enum logic [2:0]
	{
		CAUSE_NONE,
		CAUSE_INEXACT,
		CAUSE_INPUT,
		CAUSE_INVALID,
		CAUSE_UNDERFLOW
	} fpx_cause_t;

	// Whole state of the exception unit
	typedef struct packed
	{
		logic       bounce;
		fpx_cause_t cause;
		logic       capture;
		logic       preTrig;
		logic       regWrite;
		logic       flushZero;
		logic       ufTrapArmed;
		logic       excPending;
		logic       excUnderflow;
		logic       excInvalid;
		logic       ufSticky;
		logic       ixSticky;
		logic       ioSticky;
	} fpx_state_t;

endpackage

/* File: include/fpx_regs.svh */
`ifndef FPX_REGS_SVH
`define FPX_REGS_SVH

// Sticky and control field positions in the status/control word
`define FPX_SC_IO_STICKY_BIT 0
`define FPX_SC_UF_STICKY_BIT 3
`define FPX_SC_IX_STICKY_BIT 4
`define FPX_SC_IO_TRAP_BIT   8
`define FPX_SC_UF_TRAP_BIT   11
`define FPX_SC_IX_TRAP_BIT   12
`define FPX_SC_FLUSH_BIT     24
`define FPX_SC_DEF_NAN_BIT   25

// Field positions in the exception word
`define FPX_XW_IO_BIT        0
`define FPX_XW_UF_BIT        3
`define FPX_XW_PEND_BIT      31

// Smallest biased exponent of a normal number
`define FPX_MIN_NORMAL_EXP  13'sh0001

// Operand field widths
`define FPX_DP_EXP_W        11
`define FPX_DP_FRAC_W       52
`define FPX_SP_EXP_W        8
`define FPX_SP_FRAC_W       23

`endif

/* File: verification/fpx_host_model.sv */
`timescale 1ns/1ps

// Support code on the host core: confirms underflow and clears flags
module fpx_host_model
	import fpx_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               srst,
	// Bounce report and current stickies
	input  wire logic               bounce,
	input  wire fpx_cause_t         bounceCause,
	input  wire logic               underflowSticky,
	input  wire logic               inexactSticky,
	input  wire logic               invalidSticky,
	// Rounded exponent seen by support code, clear request
	input  wire logic signed [12:0] roundedExp,
	input  wire logic               clearReq,
	// Software writes
	output logic                    swWriteStatus,
	output logic [31:0]             swStatusValue,
	output logic                    swWriteExc,
	output logic [31:0]             swExcValue
);
	logic confirm;

	// Underflow holds only below the smallest normal after rounding
	assign confirm = bounce && bounceCause == CAUSE_UNDERFLOW
		&& roundedExp < 13'sh0001;

	// Strobes last one cycle; data flips when unqualified so stale
	// values cannot pass for a real write
	always_ff @(posedge clock)
	begin
		swWriteStatus <= 1'b0;
		swWriteExc <= 1'b0;
		swStatusValue <= ~swStatusValue;
		swExcValue <= ~swExcValue;
		if (srst)
		begin
			swStatusValue <= 32'h0;
			swExcValue <= 32'h0;
		end
		else if (clearReq)
		begin
			swWriteStatus <= 1'b1;
			swStatusValue <= 32'h0;
			swWriteExc <= 1'b1;
			swExcValue <= 32'h0;
		end
		else if (confirm)
		begin
			// Read-modify-write keeps the other stickies
			swWriteStatus <= 1'b1;
			swStatusValue <= {27'h0, inexactSticky, 1'b1, 2'h0,
				invalidSticky};
		end
	end
endmodule

/* File: verification/test_fp_underflow_inexact_input_exc.sv */
`timescale 1ns/1ps

module test_fp_underflow_inexact_input_exc
	import fpx_pkg::*;
;
	localparam logic [31:0] ctlInv = 32'h100;
	localparam logic [31:0] ctlUf = 32'h800;
	localparam logic [31:0] ctlIx = 32'h1000;
	localparam logic [31:0] ctlFlush = 32'h1000000;
	localparam logic [31:0] ctlDefNan = 32'h2000000;
	// Stimulus
	logic               clock, srst, issueValid, issueArith, isDp;
	logic [2:0]         opValid;
	logic [2:0][10:0]   opExp;
	logic [2:0][51:0]   opFrac;
	logic signed [12:0] initExp, ufThreshold, resExp, roundedExp, ie, rx;
	logic               resultValid, resFracAllOnes, resRoundInc;
	logic               roundInexact, ovfUntrapped, ufLossUntrapped;
	logic               fastIeeeBypassMode, clearReq;
	logic               swWriteStatus, swWriteExc;
	logic [31:0]        fpStatusCtrl, swStatusValue, swExcValue, rc;
	// Outputs
	logic               bounce, captureInstr, preTriggerValid, regWriteEn;
	logic               flushZeroResult, ufTrapArmed, excPending;
	logic               excUnderflow, excInvalid, underflowSticky;
	logic               inexactSticky, invalidSticky;
	fpx_cause_t         bounceCause, lastCause;
	// Expected flags and counters
	logic               ePend, eExUf, eExIo, eUf, eIx, eIo;
	int                 error_cnt, compares, cycles;

	fpx_exc_unit fpx_exc_unit_i (.clock, .srst, .issueValid, .issueArith,
		.isDp, .opValid, .opExp, .opFrac, .initExp, .ufThreshold,
		.resultValid, .resExp, .resFracAllOnes, .resRoundInc, .roundInexact,
		.ovfUntrapped, .ufLossUntrapped, .fpStatusCtrl, .fastIeeeBypassMode,
		.swWriteStatus, .swStatusValue, .swWriteExc, .swExcValue, .bounce,
		.bounceCause, .captureInstr, .preTriggerValid, .regWriteEn,
		.flushZeroResult, .ufTrapArmed, .excPending, .excUnderflow,
		.excInvalid, .underflowSticky, .inexactSticky, .invalidSticky);

	fpx_host_model fpx_host_model_i (.clock, .srst, .bounce, .bounceCause,
		.underflowSticky, .inexactSticky, .invalidSticky, .roundedExp,
		.clearReq, .swWriteStatus, .swStatusValue, .swWriteExc, .swExcValue);

	// Clock and hang guard sized well above the planned run
	always #2.5 clock = ~clock;
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("Counts: compares=%0d errors=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkFlags();
		chk(32'({excPending, excUnderflow, excInvalid, underflowSticky,
			inexactSticky, invalidSticky}),
			32'({ePend, eExUf, eExIo, eUf, eIx, eIo}));
	endtask

	// Bounce decision worked out from operand kinds: 0 normal,
	// 1 subnormal, 2 quiet NaN, 3 signalling NaN
	function automatic fpx_cause_t expCause(input logic [31:0] c,
		input logic ar, input logic [2:0] ov, input logic [2:0][1:0] k,
		input logic signed [12:0] ie, th, input logic fa, output logic sn);
		logic nan, sub;
		nan = 1'b0;
		sub = 1'b0;
		sn = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			nan |= ov[i] && k[i][1];
			sn |= ov[i] && k[i] == 2'h3;
			sub |= ov[i] && k[i] == 2'h1;
		end
		if (c[12])
			return CAUSE_INEXACT;
		if (!ar)
			return CAUSE_NONE;
		if ((nan && !c[25]) || (sub && !c[24]))
			return CAUSE_INPUT;
		// A signalling NaN that gets here is in default NaN mode
		if (sn)
			return c[8] ? CAUSE_INVALID : CAUSE_NONE;
		if (!fa && !c[24] && ie < th)
			return CAUSE_UNDERFLOW;
		return CAUSE_NONE;
	endfunction

	task automatic doIssue(input logic [31:0] c, input logic ar, dp,
		input logic [2:0] ov, input logic [2:0][1:0] k,
		input logic signed [12:0] ie, th, re, input logic fa);
		fpx_cause_t ec;
		logic sn, b;
		ec = expCause(c, ar, ov, k, ie, th, fa, sn);
		b = ec != CAUSE_NONE;
		@(posedge clock);
		fpStatusCtrl <= c;
		issueValid <= 1'b1;
		issueArith <= ar;
		isDp <= dp;
		opValid <= ov;
		initExp <= ie;
		ufThreshold <= th;
		roundedExp <= re;
		fastIeeeBypassMode <= fa;
		for (int i = 0; i < 3; i++)
		begin
			opExp[i] <= k[i][1] ? (dp ? 11'h7ff : 11'h0ff)
				: (k[i] == 2'h1 ? 11'h0 : (dp ? 11'h3ff : 11'h07f));
			opFrac[i] <= k[i] == 2'h2 ? (dp ? 52'h8000000000000 : 52'h400000)
				: 52'($urandom % 4096) | 52'h1;
		end
		@(posedge clock);
		issueValid <= 1'b0;
		#1;
		if (b)
			lastCause = ec;
		if (b && ec != CAUSE_INEXACT)
			ePend = 1'b1;
		eExUf |= ec == CAUSE_UNDERFLOW;
		eExIo |= ec == CAUSE_INVALID;
		eIo |= ar && sn && ec == CAUSE_NONE;
		chk(32'(bounce), 32'(b));
		chk(32'(bounceCause), 32'(lastCause));
		chk(32'({captureInstr, preTriggerValid, regWriteEn}),
			32'({b && ec != CAUSE_INEXACT, 2'h0}));
		chk(32'(ufTrapArmed), 32'(c[11] && !c[24]));
		chkFlags();
		repeat (3) @(posedge clock);
		#1;
		eUf |= ec == CAUSE_UNDERFLOW && re < 13'sh0001;
		chkFlags();
	endtask

	task automatic doResult(input logic [31:0] c,
		input logic signed [12:0] re, input logic ao, inc, rx, ov, ul);
		logic fl, wr;
		wr = !c[12];
		fl = wr && c[24] && re < 13'sh0001;
		@(posedge clock);
		fpStatusCtrl <= c;
		resultValid <= 1'b1;
		resExp <= re;
		resFracAllOnes <= ao;
		resRoundInc <= inc;
		roundInexact <= rx | fl;
		ovfUntrapped <= ov;
		ufLossUntrapped <= ul;
		@(posedge clock);
		resultValid <= 1'b0;
		#1;
		eUf |= fl;
		eIx |= wr && (rx | ov | ul | fl);
		chk(32'(regWriteEn), 32'(wr));
		chk(32'(flushZeroResult), 32'(fl));
		chkFlags();
	endtask

	// Software clear through the host model
	task automatic clearAll();
		@(posedge clock);
		clearReq <= 1'b1;
		@(posedge clock);
		clearReq <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		{ePend, eExUf, eExIo, eUf, eIx, eIo} = 6'h0;
		chkFlags();
	endtask

	// Main sequence
	initial
	begin
		{clock, issueValid, issueArith, isDp, resultValid, clearReq} = 6'h0;
		{resFracAllOnes, resRoundInc, roundInexact, ovfUntrapped} = 4'h0;
		{ufLossUntrapped, fastIeeeBypassMode, opValid} = 5'h0;
		{opExp, opFrac, initExp, ufThreshold, resExp, roundedExp} = '0;
		{ePend, eExUf, eExIo, eUf, eIx, eIo} = 6'h0;
		fpStatusCtrl = 32'h0;
		lastCause = CAUSE_NONE;
		void'($urandom(62773));
		srst = 1'b1;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		chk(32'({bounce, captureInstr, preTriggerValid, regWriteEn,
			flushZeroResult, ufTrapArmed, bounceCause}), 32'h0);
		chkFlags();
		$display("Test done: reset");
		doIssue(ctlUf, 1'h1, 1'h1, 3'h3, 6'h0, 13'sh0, 13'sh1, 13'sh0, 1'h0);
		doIssue(32'h0, 1'h1, 1'h0, 3'h7, 6'h0, 13'sh2, 13'sh3, 13'sh1, 1'h0);
		doIssue(ctlUf | ctlFlush, 1'h1, 1'h1, 3'h3, 6'h0, 13'sh0, 13'sh1, 13'sh0, 1'h0);
		doIssue(ctlUf, 1'h1, 1'h1, 3'h3, 6'h0, 13'sh0, 13'sh1, 13'sh0, 1'h1);
		doIssue(ctlIx, 1'h1, 1'h1, 3'h7, 6'h2, 13'sh0, 13'sh1, 13'sh0, 1'h0);
		doIssue(ctlIx, 1'h0, 1'h0, 3'h0, 6'h0, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(32'h0, 1'h1, 1'h1, 3'h1, 6'h2, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(ctlDefNan, 1'h1, 1'h0, 3'h1, 6'h2, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(32'h0, 1'h1, 1'h0, 3'h2, 6'h4, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(ctlFlush, 1'h1, 1'h1, 3'h2, 6'h4, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(ctlDefNan | ctlInv, 1'h1, 1'h1, 3'h4, 6'h30, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(ctlDefNan, 1'h1, 1'h0, 3'h4, 6'h30, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(32'h0, 1'h1, 1'h1, 3'h4, 6'h30, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		doIssue(32'h0, 1'h1, 1'h1, 3'h0, 6'h3f, 13'sh2, 13'sh1, 13'sh1, 1'h0);
		$display("Test done: issue corners");
		clearAll();
		doResult(ctlFlush, 13'sh0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
		doResult(ctlFlush, 13'sh1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
		doResult(ctlFlush, -13'sh3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		clearAll();
		doResult(32'h0, 13'sh5, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
		doResult(32'h0, 13'sh5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		clearAll();
		doResult(32'h0, 13'sh5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
		clearAll();
		doResult(ctlIx, 13'sh5, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		doResult(32'h0, 13'sh5, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		$display("Test done: result corners");
		for (int n = 0; n < 150; n++)
		begin
			rc = 32'($urandom) & 32'h3001900;
			if ($urandom % 4 != 0)
				rc[12] = 1'b0;
			ie = 13'($urandom % 8);
			rx = 13'($urandom % 4) - 13'sh1;
			doIssue(rc, 1'($urandom), 1'($urandom), 3'($urandom), 6'($urandom),
				ie, 13'($urandom % 8), 13'($urandom % 2), 1'($urandom));
			doResult(rc, rx, 1'($urandom), 1'($urandom), 1'($urandom),
				1'($urandom), 1'($urandom));
		end
		clearAll();
		$display("Test done: random");
		end_sim();
	end
endmodule
